// ---- core/oag_defines.svh ----
// Constants of the operand address generator
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH

`define OAG_RESET_IP      16'h0000
`define OAG_RESET_CSB     16'h0000
`define OAG_RESET_WORD    16'h0000

`define OAG_STEP_BYTE     16'h0001
`define OAG_STEP_WORD     16'h0002
`define OAG_PTR_HI_OFS    16'h0002

`define OAG_REG_ACC       3'h0
`define OAG_REG_COUNT     3'h1
`define OAG_REG_PORT      3'h2
`define OAG_REG_BASE_WORD 3'h3
`define OAG_REG_STACK     3'h4
`define OAG_REG_BASE_PTR  3'h5
`define OAG_REG_SRC_IDX   3'h6
`define OAG_REG_DST_IDX   3'h7

`define OAG_MOD_NODISP    2'h0
`define OAG_MOD_DISP8     2'h1
`define OAG_MOD_DISP16    2'h2
`define OAG_MOD_REG       2'h3

`define OAG_RM_BW_SI      3'h0
`define OAG_RM_BW_DI      3'h1
`define OAG_RM_BP_SI      3'h2
`define OAG_RM_BP_DI      3'h3
`define OAG_RM_SI         3'h4
`define OAG_RM_DI         3'h5
`define OAG_RM_BP         3'h6
`define OAG_RM_BW         3'h7
`define OAG_RM_DIRECT     3'h6

`define OAG_IO_LOW_MASK   16'h00ff
`define OAG_BYTE_SIGN     7
`define OAG_BYTE_MSB      7
`define OAG_WORD_LO_MSB   15
`define OAG_WORD_HI_LSB   16
`define OAG_FIELD_MOD_MSB 4
`define OAG_FIELD_MOD_LSB 3
`define OAG_FIELD_RM_MSB  2

`endif

// ---- core/oag_pkg.sv ----
// Types of the operand address generator
package oag_pkg;

    typedef enum logic [2:0] {
        OAG_BR_FAR,
        OAG_BR_REL8,
        OAG_BR_REL16,
        OAG_BR_REG,
        OAG_BR_MEM16,
        OAG_BR_MEM32
    } oag_br_mode_t;

    typedef enum logic [2:0] {
        OAG_OP_REG,
        OAG_OP_BYTE_IMMEDIATE,
        OAG_OP_IMM16,
        OAG_OP_IO_BYTE_IMMEDIATE,
        OAG_OP_IO_PORTREG
    } oag_op_src_t;

    typedef enum logic [1:0] {
        OAG_SEG_DATA0,
        OAG_SEG_DATA1,
        OAG_SEG_CODE,
        OAG_SEG_STACK
    } oag_seg_t;

    typedef enum logic [1:0] {
        OAG_IDLE,
        OAG_RD_LO,
        OAG_RD_HI
    } oag_state_t;

    typedef struct packed {
        oag_state_t st;
        logic [15:0] instruction_pointer;
        logic [15:0] code_segment_base;
        logic        br_done;
        logic        far_ptr;
        logic [15:0] ptr_lo;
        logic        mem_req;
        logic [15:0] mem_addr;
        oag_seg_t    mem_seg;
        logic [15:0] ea_offset;
        oag_seg_t    ea_seg;
        logic        ea_valid;
        logic        ea_is_reg;
        logic [15:0] opnd_value;
        logic        opnd_valid;
        logic [15:0] io_addr;
        logic        io_valid;
        logic        dest_fault;
    } oag_state_s_t;

endpackage

// ---- core/oag_ea_adder.sv ----
// Three-term effective address adder
`timescale 1ns/1ps
module oag_ea_adder
    import oag_pkg::*;
(
    input  wire logic        base_en,
    input  wire logic [15:0] base_val,
    input  wire logic        index_en,
    input  wire logic [15:0] index_val,
    input  wire logic        disp_en,
    input  wire logic [15:0] disp_val,
    output logic      [15:0] offset
);
    logic [17:0] sum;

    always_comb begin
        sum = {2'h0, base_en ? base_val : 16'h0000}
            + {2'h0, index_en ? index_val : 16'h0000}
            + {2'h0, disp_en ? disp_val : 16'h0000};
        offset = sum[15:0];
    end
endmodule // oag_ea_adder

// ---- core/oag_top.sv ----
// Operand and branch address generator of the execution unit
`timescale 1ns/1ps
`include "oag_defines.svh"
module oag_top
    import oag_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         fetch_valid,
    input  wire logic         fetch_word,
    input  wire logic         branch_valid,
    input  wire oag_br_mode_t branch_mode,
    input  wire logic [31:0]  branch_imm,
    input  wire logic [15:0]  next_instr_addr,
    input  wire logic [2:0]   branch_reg_sel,
    input  wire logic         ea_req,
    input  wire logic [4:0]   ea_field,
    input  wire logic [15:0]  ea_disp,
    input  wire logic         seg_override_valid,
    input  wire oag_seg_t     seg_override,
    input  wire logic         op_req,
    input  wire oag_op_src_t  op_src,
    input  wire logic [2:0]   op_reg_sel,
    input  wire logic [15:0]  op_imm,
    input  wire logic         op_is_dest,
    input  wire logic [15:0]  acc_reg,
    input  wire logic [15:0]  count_reg,
    input  wire logic [15:0]  port_number_reg,
    input  wire logic [15:0]  base_word_reg,
    input  wire logic [15:0]  stack_ptr_reg,
    input  wire logic [15:0]  base_pointer_reg,
    input  wire logic [15:0]  source_index_reg,
    input  wire logic [15:0]  dest_index_reg,
    input  wire logic         mem_ready,
    input  wire logic [15:0]  mem_rdata,
    output logic              busy,
    output logic [15:0]       instruction_pointer,
    output logic [15:0]       code_segment_base,
    output logic              branch_done,
    output logic              mem_req,
    output logic [15:0]       mem_addr,
    output oag_seg_t          mem_seg,
    output logic [15:0]       ea_offset,
    output oag_seg_t          ea_seg,
    output logic              ea_valid,
    output logic              ea_is_reg,
    output logic [15:0]       opnd_value,
    output logic              opnd_valid,
    output logic [15:0]       io_addr,
    output logic              io_valid,
    output logic              dest_fault
);
    oag_state_s_t s_q;
    oag_state_s_t s_d;

    logic [1:0]  ea_mod;
    logic [2:0]  ea_rm;
    logic        add_base_en;
    logic [15:0] add_base;
    logic        add_index_en;
    logic [15:0] add_index;
    logic        add_disp_en;
    logic [15:0] add_disp;
    logic [15:0] ea_now;
    oag_seg_t    seg_now;
    logic        br_go;

    function automatic logic [15:0] sext8(input logic [15:0] v);
        sext8 = {{8{v[`OAG_BYTE_SIGN]}}, v[`OAG_BYTE_MSB:0]};
    endfunction

    function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        add16 = t[15:0];
    endfunction

    function automatic logic [15:0] reg_pick(input logic [2:0] sel);
        logic [15:0] r;
        r = acc_reg;
        unique case (sel)
            `OAG_REG_ACC:       r = acc_reg;
            `OAG_REG_COUNT:     r = count_reg;
            `OAG_REG_PORT:      r = port_number_reg;
            `OAG_REG_BASE_WORD: r = base_word_reg;
            `OAG_REG_STACK:     r = stack_ptr_reg;
            `OAG_REG_BASE_PTR:  r = base_pointer_reg;
            `OAG_REG_SRC_IDX:   r = source_index_reg;
            `OAG_REG_DST_IDX:   r = dest_index_reg;
        endcase
        reg_pick = r;
    endfunction

    // Addressing field decode into adder terms and default segment
    always_comb begin
        ea_mod       = ea_field[`OAG_FIELD_MOD_MSB:`OAG_FIELD_MOD_LSB];
        ea_rm        = ea_field[`OAG_FIELD_RM_MSB:0];
        add_base_en  = 1'b0;
        add_base     = base_word_reg;
        add_index_en = 1'b0;
        add_index    = source_index_reg;
        add_disp_en  = (ea_mod == `OAG_MOD_DISP8) || (ea_mod == `OAG_MOD_DISP16);
        add_disp     = (ea_mod == `OAG_MOD_DISP8) ? sext8(ea_disp) : ea_disp;
        seg_now      = OAG_SEG_DATA0;
        unique case (ea_rm)
            `OAG_RM_BW_SI: begin
                add_base_en  = 1'b1;
                add_index_en = 1'b1;
            end
            `OAG_RM_BW_DI: begin
                add_base_en  = 1'b1;
                add_index_en = 1'b1;
                add_index    = dest_index_reg;
            end
            `OAG_RM_BP_SI: begin
                add_base_en  = 1'b1;
                add_base     = base_pointer_reg;
                add_index_en = 1'b1;
                seg_now      = OAG_SEG_STACK;
            end
            `OAG_RM_BP_DI: begin
                add_base_en  = 1'b1;
                add_base     = base_pointer_reg;
                add_index_en = 1'b1;
                add_index    = dest_index_reg;
                seg_now      = OAG_SEG_STACK;
            end
            `OAG_RM_SI: begin
                add_index_en = 1'b1;
            end
            `OAG_RM_DI: begin
                add_index_en = 1'b1;
                add_index    = dest_index_reg;
            end
            `OAG_RM_BP: begin
                if (ea_mod == `OAG_MOD_NODISP) begin
                    add_disp_en = 1'b1;
                    add_disp    = ea_disp;
                end else begin
                    add_base_en = 1'b1;
                    add_base    = base_pointer_reg;
                    seg_now     = OAG_SEG_STACK;
                end
            end
            `OAG_RM_BW: begin
                add_base_en = 1'b1;
            end
        endcase
        // An override always beats the default, stack included
        if (seg_override_valid) begin
            seg_now = seg_override;
        end
    end

    oag_ea_adder u_adder (
        .base_en   (add_base_en),
        .base_val  (add_base),
        .index_en  (add_index_en),
        .index_val (add_index),
        .disp_en   (add_disp_en),
        .disp_val  (add_disp),
        .offset    (ea_now)
    );

    // A pointer read in flight blocks new branches and fetch steps
    assign br_go = branch_valid && (s_q.st == OAG_IDLE);

    always_comb begin
        s_d            = s_q;
        s_d.br_done    = 1'b0;
        s_d.ea_valid   = 1'b0;
        s_d.opnd_valid = 1'b0;
        s_d.io_valid   = 1'b0;
        s_d.dest_fault = 1'b0;

        unique case (s_q.st)
            OAG_IDLE: begin
                if (br_go) begin
                    unique case (branch_mode)
                        OAG_BR_FAR: begin
                            s_d.instruction_pointer = branch_imm[`OAG_WORD_LO_MSB:0];
                            s_d.code_segment_base   = branch_imm[31:`OAG_WORD_HI_LSB];
                            s_d.br_done             = 1'b1;
                        end
                        OAG_BR_REL8: begin
                            s_d.instruction_pointer = add16(next_instr_addr, sext8(branch_imm[15:0]));
                            s_d.br_done             = 1'b1;
                        end
                        OAG_BR_REL16: begin
                            s_d.instruction_pointer = add16(next_instr_addr, branch_imm[15:0]);
                            s_d.br_done             = 1'b1;
                        end
                        OAG_BR_REG: begin
                            s_d.instruction_pointer = reg_pick(branch_reg_sel);
                            s_d.br_done             = 1'b1;
                        end
                        OAG_BR_MEM16, OAG_BR_MEM32: begin
                            s_d.far_ptr  = (branch_mode == OAG_BR_MEM32);
                            s_d.mem_req  = 1'b1;
                            s_d.mem_addr = ea_now;
                            s_d.mem_seg  = seg_now;
                            s_d.st       = OAG_RD_LO;
                        end
                        default: begin
                            s_d.br_done = 1'b0;
                        end
                    endcase
                end else if (fetch_valid) begin
                    // Step width follows the fetch, so an odd target resumes word fetches
                    s_d.instruction_pointer = add16(s_q.instruction_pointer,
                                                    fetch_word ? `OAG_STEP_WORD : `OAG_STEP_BYTE);
                end
            end
            OAG_RD_LO: begin
                // Ready low holds the cycle as a wait state
                if (mem_ready) begin
                    if (s_q.far_ptr) begin
                        s_d.ptr_lo   = mem_rdata;
                        s_d.mem_addr = add16(s_q.mem_addr, `OAG_PTR_HI_OFS);
                        s_d.st       = OAG_RD_HI;
                    end else begin
                        s_d.instruction_pointer = mem_rdata;
                        s_d.mem_req             = 1'b0;
                        s_d.br_done             = 1'b1;
                        s_d.st                  = OAG_IDLE;
                    end
                end
            end
            OAG_RD_HI: begin
                if (mem_ready) begin
                    s_d.instruction_pointer = s_q.ptr_lo;
                    s_d.code_segment_base   = mem_rdata;
                    s_d.mem_req             = 1'b0;
                    s_d.br_done             = 1'b1;
                    s_d.st                  = OAG_IDLE;
                end
            end
        endcase

        if (ea_req) begin
            s_d.ea_offset = ea_now;
            s_d.ea_seg    = seg_now;
            s_d.ea_is_reg = (ea_mod == `OAG_MOD_REG);
            s_d.ea_valid  = 1'b1;
        end

        if (op_req) begin
            s_d.opnd_valid = 1'b1;
            unique case (op_src)
                OAG_OP_REG: begin
                    s_d.opnd_value = reg_pick(op_reg_sel);
                end
                OAG_OP_BYTE_IMMEDIATE: begin
                    s_d.opnd_value = {8'h00, op_imm[`OAG_BYTE_MSB:0]};
                    s_d.dest_fault = op_is_dest;
                end
                OAG_OP_IMM16: begin
                    s_d.opnd_value = op_imm;
                    s_d.dest_fault = op_is_dest;
                end
                OAG_OP_IO_BYTE_IMMEDIATE: begin
                    s_d.io_addr    = op_imm & `OAG_IO_LOW_MASK;
                    s_d.io_valid   = 1'b1;
                    s_d.opnd_valid = 1'b0;
                end
                OAG_OP_IO_PORTREG: begin
                    s_d.io_addr    = port_number_reg;
                    s_d.io_valid   = 1'b1;
                    s_d.opnd_valid = 1'b0;
                end
                default: begin
                    s_d.opnd_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.st                  <= OAG_IDLE;
            s_q.instruction_pointer <= `OAG_RESET_IP;
            s_q.code_segment_base   <= `OAG_RESET_CSB;
            s_q.br_done             <= 1'b0;
            s_q.far_ptr             <= 1'b0;
            s_q.ptr_lo              <= `OAG_RESET_WORD;
            s_q.mem_req             <= 1'b0;
            s_q.mem_addr            <= `OAG_RESET_WORD;
            s_q.mem_seg             <= OAG_SEG_DATA0;
            s_q.ea_offset           <= `OAG_RESET_WORD;
            s_q.ea_seg              <= OAG_SEG_DATA0;
            s_q.ea_valid            <= 1'b0;
            s_q.ea_is_reg           <= 1'b0;
            s_q.opnd_value          <= `OAG_RESET_WORD;
            s_q.opnd_valid          <= 1'b0;
            s_q.io_addr             <= `OAG_RESET_WORD;
            s_q.io_valid            <= 1'b0;
            s_q.dest_fault          <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy                = (s_q.st != OAG_IDLE);
    assign instruction_pointer = s_q.instruction_pointer;
    assign code_segment_base   = s_q.code_segment_base;
    assign branch_done         = s_q.br_done;
    assign mem_req             = s_q.mem_req;
    assign mem_addr            = s_q.mem_addr;
    assign mem_seg             = s_q.mem_seg;
    assign ea_offset           = s_q.ea_offset;
    assign ea_seg              = s_q.ea_seg;
    assign ea_valid            = s_q.ea_valid;
    assign ea_is_reg           = s_q.ea_is_reg;
    assign opnd_value          = s_q.opnd_value;
    assign opnd_valid          = s_q.opnd_valid;
    assign io_addr             = s_q.io_addr;
    assign io_valid            = s_q.io_valid;
    assign dest_fault          = s_q.dest_fault;
endmodule // oag_top

// ---- verification/oag_checker.sv ----
// Concurrent checks on the ports of the operand address generator
`timescale 1ns/1ps
module oag_checker
    import oag_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         fetch_valid,
    input wire logic         fetch_word,
    input wire logic         branch_valid,
    input wire oag_br_mode_t branch_mode,
    input wire logic [31:0]  branch_imm,
    input wire logic [15:0]  next_instr_addr,
    input wire logic         ea_req,
    input wire logic [4:0]   ea_field,
    input wire logic         seg_override_valid,
    input wire logic         op_req,
    input wire oag_op_src_t  op_src,
    input wire logic [15:0]  op_imm,
    input wire logic         op_is_dest,
    input wire logic [15:0]  port_number_reg,
    input wire logic         mem_ready,
    input wire logic [15:0]  mem_rdata,
    input wire logic         busy,
    input wire logic [15:0]  instruction_pointer,
    input wire logic [15:0]  code_segment_base,
    input wire logic         branch_done,
    input wire logic         mem_req,
    input wire logic [15:0]  mem_addr,
    input wire oag_seg_t     ea_seg,
    input wire logic         ea_valid,
    input wire logic [15:0]  io_addr,
    input wire logic         io_valid,
    input wire logic         dest_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_br(m);
        branch_valid && !busy && branch_mode == m;
    endsequence
    sequence s_rd;
        mem_req && mem_ready;
    endsequence

    a_fetch_step: assert property (fetch_valid && !busy && !branch_valid |=>
        instruction_pointer == $past(instruction_pointer) + ($past(fetch_word) ? 16'h0002 : 16'h0001))
        else $error("fetch step wrong");
    a_far_load: assert property (s_br(OAG_BR_FAR) |=> branch_done &&
        instruction_pointer == $past(branch_imm[15:0]) && code_segment_base == $past(branch_imm[31:16]))
        else $error("far branch load wrong");
    a_rel_short: assert property (s_br(OAG_BR_REL8) |=> instruction_pointer ==
        $past(next_instr_addr) + {{8{$past(branch_imm[7])}}, $past(branch_imm[7:0])})
        else $error("short relative target wrong");
    // Waits hold the read; the pointer moves only once data arrives
    a_mem_word: assert property (s_br(OAG_BR_MEM16) ##1 (mem_req && !mem_ready)[*2] ##1 s_rd
        |=> branch_done && instruction_pointer == $past(mem_rdata))
        else $error("word pointer read wrong");
    a_mem_far: assert property (s_br(OAG_BR_MEM32) ##1 s_rd ##1 (s_rd and mem_addr == $past(mem_addr) + 16'h0002)
        |=> branch_done && !busy && instruction_pointer == $past(mem_rdata, 2) && code_segment_base == $past(mem_rdata))
        else $error("far pointer read wrong");
    a_ea_answer: assert property (ea_valid == $past(ea_req))
        else $error("address valid pulse wrong");
    a_bp_stack: assert property (ea_req && !seg_override_valid && ea_field[4:3] != 2'h3 &&
        (ea_field[2:1] == 2'h1 || (ea_field[2:0] == 3'h6 && ea_field[4:3] != 2'h0)) |=> ea_seg == OAG_SEG_STACK)
        else $error("stack segment default missing");
    a_io_low: assert property (op_req && op_src == OAG_OP_IO_BYTE_IMMEDIATE |=>
        io_valid && io_addr == {8'h00, $past(op_imm[7:0])})
        else $error("byte port address wrong");
    a_io_full: assert property (op_req && op_src == OAG_OP_IO_PORTREG |=>
        io_valid && io_addr == $past(port_number_reg))
        else $error("register port address wrong");
    a_imm_dest: assert property (op_req && op_is_dest && (op_src == OAG_OP_BYTE_IMMEDIATE || op_src == OAG_OP_IMM16)
        |=> dest_fault)
        else $error("immediate destination not flagged");
endmodule // oag_checker

bind oag_top oag_checker u_chk (.clk, .rst, .fetch_valid, .fetch_word, .branch_valid, .branch_mode, .branch_imm,
    .next_instr_addr, .ea_req, .ea_field, .seg_override_valid, .op_req, .op_src, .op_imm, .op_is_dest,
    .port_number_reg, .mem_ready, .mem_rdata, .busy, .instruction_pointer, .code_segment_base, .branch_done,
    .mem_req, .mem_addr, .ea_seg, .ea_valid, .io_addr, .io_valid, .dest_fault);

// ---- verification/oag_top_tb.sv ----
// Self-checking testbench of the operand address generator
`timescale 1ns/1ps
module oag_top_tb
    import oag_pkg::*;
;
    typedef struct packed {
        logic        ovr;
        oag_seg_t    ovs;
        logic [4:0]  f;
        logic [15:0] d;
        logic [15:0] off;
        oag_seg_t    seg;
        logic        isr;
    } oag_row_t;

    logic         clk = 1'b0, rst = 1'b1, fetch_valid = 1'b0, fetch_word = 1'b0, branch_valid = 1'b0;
    oag_br_mode_t branch_mode = OAG_BR_FAR;
    logic [31:0]  branch_imm = 32'h0;
    logic [15:0]  next_instr_addr = 16'h0, ea_disp = 16'h0, op_imm = 16'h0, mem_rdata = 16'h0;
    logic [2:0]   branch_reg_sel = 3'h0, op_reg_sel = 3'h0;
    logic [4:0]   ea_field = 5'h0;
    logic         ea_req = 1'b0, seg_override_valid = 1'b0, op_req = 1'b0, op_is_dest = 1'b0, mem_ready = 1'b0;
    oag_seg_t     seg_override = OAG_SEG_DATA0;
    oag_op_src_t  op_src = OAG_OP_REG;
    logic         busy, branch_done, mem_req, ea_valid, ea_is_reg, opnd_valid, io_valid, dest_fault;
    logic [15:0]  instruction_pointer, code_segment_base, mem_addr, ea_offset, opnd_value, io_addr;
    oag_seg_t     mem_seg, ea_seg;
    int           errors = 0, n_compared = 0, cycles = 0;
    // Register file contents, indexed by register code
    logic [15:0]  regv [8] = '{16'ha5a5, 16'h0c0c, 16'h8421, 16'h1000, 16'h7ffe, 16'h2000, 16'h0030, 16'h0400};
    // Unused displacement bits are set on purpose to catch a sloppy decode
    oag_row_t     rows [12] = '{
        '{1'b0, OAG_SEG_DATA0, 5'h00, 16'h5555, 16'h1030, OAG_SEG_DATA0, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h01, 16'h0000, 16'h1400, OAG_SEG_DATA0, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h0a, 16'h00f0, 16'h2020, OAG_SEG_STACK, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h13, 16'h0100, 16'h2500, OAG_SEG_STACK, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h04, 16'hffff, 16'h0030, OAG_SEG_DATA0, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h0d, 16'h0005, 16'h0405, OAG_SEG_DATA0, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h0e, 16'h0080, 16'h1f80, OAG_SEG_STACK, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h17, 16'hf000, 16'h0000, OAG_SEG_DATA0, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h0f, 16'hab7f, 16'h107f, OAG_SEG_DATA0, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h06, 16'h1234, 16'h1234, OAG_SEG_DATA0, 1'b0},
        '{1'b1, OAG_SEG_DATA1, 5'h16, 16'h0010, 16'h2010, OAG_SEG_DATA1, 1'b0},
        '{1'b0, OAG_SEG_DATA0, 5'h18, 16'h0000, 16'h0000, OAG_SEG_DATA0, 1'b1}
    };

    oag_top DUT (.clk, .rst, .fetch_valid, .fetch_word, .branch_valid, .branch_mode, .branch_imm, .next_instr_addr,
        .branch_reg_sel, .ea_req, .ea_field, .ea_disp, .seg_override_valid, .seg_override, .op_req, .op_src,
        .op_reg_sel, .op_imm, .op_is_dest, .acc_reg(regv[0]), .count_reg(regv[1]), .port_number_reg(regv[2]),
        .base_word_reg(regv[3]), .stack_ptr_reg(regv[4]), .base_pointer_reg(regv[5]), .source_index_reg(regv[6]),
        .dest_index_reg(regv[7]), .mem_ready, .mem_rdata, .busy, .instruction_pointer, .code_segment_base,
        .branch_done, .mem_req, .mem_addr, .mem_seg, .ea_offset, .ea_seg, .ea_valid, .ea_is_reg, .opnd_value,
        .opnd_valid, .io_addr, .io_valid, .dest_fault);

    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic give_verdict;
        $display("compared %0d, mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Each request task first lets an edge pass, so a strobe is never lowered and raised in one step
    task automatic br(input oag_br_mode_t m, input logic [31:0] imm, input logic f);
        @(negedge clk);
        branch_valid = 1'b1;
        branch_mode = m;
        branch_imm = imm;
        fetch_valid = f;
        @(negedge clk);
        branch_valid = 1'b0;
        fetch_valid = 1'b0;
    endtask

    task automatic fe(input logic w);
        @(negedge clk);
        fetch_valid = 1'b1;
        fetch_word = w;
        @(negedge clk);
        fetch_valid = 1'b0;
    endtask

    task automatic ea(input logic [4:0] f, input logic [15:0] d);
        @(negedge clk);
        ea_req = 1'b1;
        ea_field = f;
        ea_disp = d;
        @(negedge clk);
        ea_req = 1'b0;
    endtask

    task automatic op(input oag_op_src_t s, input logic [2:0] sel, input logic [15:0] imm, input logic dst);
        @(negedge clk);
        op_req = 1'b1;
        op_src = s;
        op_reg_sel = sel;
        op_imm = imm;
        op_is_dest = dst;
        @(negedge clk);
        op_req = 1'b0;
    endtask

    // Read data is presented for the one edge that ends the bus cycle
    task automatic rd(input logic [15:0] a, input logic [15:0] d);
        chk(mem_req, 1'b1);
        chk(mem_addr, a);
        mem_ready = 1'b1;
        mem_rdata = d;
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            give_verdict;
        end
    end

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(instruction_pointer, 16'h0000);
        chk(code_segment_base, 16'h0000);
        chk(busy, 1'b0);
        done("reset");
        ea_req = 1'b1;
        for (int i = 0; i < 12; i++) begin
            seg_override_valid = rows[i].ovr;
            seg_override = rows[i].ovs;
            ea_field = rows[i].f;
            ea_disp = rows[i].d;
            @(negedge clk);
            chk(ea_valid, 1'b1);
            chk(ea_is_reg, rows[i].isr);
            if (!rows[i].isr) begin
                chk(ea_offset, rows[i].off);
                chk(ea_seg, rows[i].seg);
            end
        end
        ea_req = 1'b0;
        seg_override_valid = 1'b0;
        done("address table");
        fe(1'b0);
        chk(instruction_pointer, 16'h0001);
        fe(1'b1);
        chk(instruction_pointer, 16'h0003);
        br(OAG_BR_FAR, 32'h1234_5678, 1'b1);
        chk(branch_done, 1'b1);
        chk(instruction_pointer, 16'h5678);
        chk(code_segment_base, 16'h1234);
        next_instr_addr = 16'h0010;
        br(OAG_BR_REL8, 32'h0000_00f0, 1'b0);
        chk(instruction_pointer, 16'h0000);
        next_instr_addr = 16'hffff;
        br(OAG_BR_REL16, 32'h0000_0003, 1'b0);
        chk(instruction_pointer, 16'h0002);
        @(negedge clk);
        branch_valid = 1'b1;
        branch_mode = OAG_BR_REG;
        for (int k = 0; k < 8; k++) begin
            branch_reg_sel = k[2:0];
            @(negedge clk);
            chk(instruction_pointer, regv[k]);
        end
        branch_valid = 1'b0;
        done("direct branches");
        ea(5'h07, 16'h0000);
        br(OAG_BR_MEM16, 32'h0, 1'b0);
        chk(busy, 1'b1);
        fe(1'b1);
        chk(instruction_pointer, 16'h0400);
        rd(16'h1000, 16'hbeef);
        mem_ready = 1'b0;
        mem_rdata = 16'h4110;
        chk(branch_done, 1'b1);
        chk(instruction_pointer, 16'hbeef);
        ea(5'h17, 16'hefff);
        br(OAG_BR_MEM32, 32'h0, 1'b0);
        rd(16'hffff, 16'h4444);
        rd(16'h0001, 16'h5555);
        mem_ready = 1'b0;
        mem_rdata = 16'haaaa;
        chk(branch_done, 1'b1);
        chk(instruction_pointer, 16'h4444);
        chk(code_segment_base, 16'h5555);
        chk(busy, 1'b0);
        done("memory indirect");
        // A reset in mid-read must drop the bus request and the pointer
        ea(5'h0e, 16'h0004);
        br(OAG_BR_MEM16, 32'h0, 1'b0);
        chk(mem_addr, 16'h2004);
        chk(mem_seg, OAG_SEG_STACK);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk(busy, 1'b0);
        chk(mem_req, 1'b0);
        chk(instruction_pointer, 16'h0000);
        done("mid-run reset");
        op(OAG_OP_BYTE_IMMEDIATE, 3'h0, 16'h12ab, 1'b0);
        chk(opnd_valid, 1'b1);
        chk(opnd_value, 16'h00ab);
        op(OAG_OP_IMM16, 3'h0, 16'h12ab, 1'b1);
        chk(opnd_value, 16'h12ab);
        chk(dest_fault, 1'b1);
        op(OAG_OP_REG, 3'h2, 16'h0000, 1'b1);
        chk(opnd_value, 16'h8421);
        chk(dest_fault, 1'b0);
        op(OAG_OP_IO_BYTE_IMMEDIATE, 3'h0, 16'hbeef, 1'b0);
        chk(io_valid, 1'b1);
        chk(io_addr, 16'h00ef);
        op(OAG_OP_IO_PORTREG, 3'h0, 16'h0000, 1'b0);
        chk(io_addr, 16'h8421);
        done("operands");
        give_verdict;
    end
endmodule // oag_top_tb
